// file: core/dbgacc_dev.sv
// Device end: decodes debug commands into CPU register and memory accesses.
// How it works
// - Register transfers always carry a 32-bit word.
// - Register index D to F: 0xEE, bad access.
// - Store opcodes 0x40-0x4C, low nibble is index.
// - Fetch opcodes 0x60-0x6C, same index order.
// - Valid widths: 8, 16, 24, 32 per register.
// - Unimplemented command ends dump, fill, same sequences.
// - Illegal read returns 0xEE in each byte of its size, zero above.
// - After illegal access, fill and same invalid.
// - Illegal access keeps a dump sequence alive.
// - Read-invalid reads keep dump and same valid.
// - 32-bit accesses force address bits [1:0] zero.
// - 16-bit at lane 11 moves to lanes 10,11.
// - Streamed address is previous plus previous size.
// - After misaligned 32-bit, increment zero-forced address.
// - After realigned 16-bit, increment original address.
// - Repeated reads use unmodified last read address.
// - Repeated reads realign per own size, keep base.
// - Store while not halted: no operation, bad command.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module dbgacc_dev
   import dbgacc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // Link to the debug host.
   dbgacc_link_if.dev       link,
   // Core state.
   input  wire logic        debug_halt_state,
   // CPU register file port.
   output logic [3:0]       cpu_reg_index,
   output logic             cpu_reg_we,
   output logic [31:0]      cpu_reg_wdata,
   input  wire logic [31:0] cpu_reg_rdata,
   // Memory port, big-endian lanes, mem_be[3] is lane 00.
   output logic             mem_req,
   output logic             mem_we,
   output logic [23:0]      mem_addr,
   output logic [3:0]       mem_be,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_illegal,
   input  wire logic        mem_read_invalid_flag
);
`include "dbgacc_consts.svh"

   // Aligned address of an access of the given size.
   function automatic logic [23:0] align_addr(input logic [23:0] a, input logic [1:0] sz);
      logic [23:0] r;
      r = a;
      if (sz == `DBGACC_SZ_32) begin
         r[1:0] = 2'h0;
      end else if (sz == `DBGACC_SZ_16 && a[1:0] == 2'h3) begin
         r[1:0] = 2'h2;
      end
      return r;
   endfunction : align_addr

   // Number of bytes minus one for a size code.
   function automatic logic [1:0] size_span(input logic [1:0] sz);
      return {sz[1], sz[1] | sz[0]};
   endfunction : size_span

   // Mask of the valid data bits of a size code.
   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      logic [31:0] m;
      case (sz)
         `DBGACC_SZ_8:  m = 32'h000000FF;
         `DBGACC_SZ_16: m = 32'h0000FFFF;
         default:       m = 32'hFFFFFFFF;
      endcase
      return m;
   endfunction : size_mask

   // Valid bits of each CPU register; the redundant bits read as zero.
   function automatic logic [31:0] reg_mask(input logic [3:0] idx);
      logic [31:0] m;
      case (idx)
         4'h0, 4'h1:                   m = 32'h000000FF;
         4'h2, 4'h3, 4'h4, 4'h5, 4'hC: m = 32'h0000FFFF;
         4'h8, 4'h9, 4'hA, 4'hB:       m = 32'h00FFFFFF;
         default:                      m = 32'hFFFFFFFF;
      endcase
      return m;
   endfunction : reg_mask

   dbgacc_state_t state_q;
   logic          fill_ok_q;
   logic          dump_ok_q;
   logic          same_ok_q;
   logic [23:0]   last_addr_q;
   logic [1:0]    last_size_q;
   logic [23:0]   base_addr_q;
   logic [1:0]    size_q;
   logic [4:0]    shift_q;
   logic          fetch_q;
   logic          rsp_valid_q;
   logic [31:0]   rsp_rdata_q;
   dbgacc_flags_t rsp_flags_q;

   logic [3:0]    cls;
   logic [1:0]    sz;
   logic          is_wr;
   logic          is_fill;
   logic          is_rd;
   logic          is_same;
   logic          is_dump;
   logic          is_sto;
   logic          is_fet;
   logic          mem_cmd;
   logic          seq_ok;
   logic          unimpl;
   logic          take;
   logic [23:0]   raw_addr;
   logic [23:0]   eff_addr;
   logic [1:0]    end_lane;

   // Command decode; the size field only means something on memory commands.
   always_comb begin
      cls      = link.cmd_op[7:4];
      sz       = link.cmd_op[3:2];
      is_wr    = cls == `DBGACC_CLS_WRITE_MEM;
      is_fill  = cls == `DBGACC_CLS_FILL_MEM;
      is_rd    = cls == `DBGACC_CLS_READ_MEM;
      is_same  = cls == `DBGACC_CLS_READ_SAME;
      is_dump  = cls == `DBGACC_CLS_DUMP_MEM;
      is_sto   = cls == `DBGACC_CLS_REG_STORE;
      is_fet   = cls == `DBGACC_CLS_REG_FETCH;
      mem_cmd  = (is_wr | is_fill | is_rd | is_same | is_dump) & (sz != 2'h3);
      unimpl   = ~(mem_cmd | is_sto | is_fet);
      seq_ok   = is_fill ? fill_ok_q : is_dump ? dump_ok_q : is_same ? same_ok_q : 1'b1;
      take     = (state_q == DBGACC_IDLE) & link.cmd_valid;
      if (is_fill | is_dump) begin
         raw_addr = last_addr_q + {22'h0, size_span(last_size_q)} + 24'h1;
      end else if (is_same) begin
         raw_addr = base_addr_q;
      end else begin
         raw_addr = link.cmd_addr;
      end
      eff_addr = align_addr(raw_addr, sz);
      end_lane = eff_addr[1:0] + size_span(sz);
   end

   assign link.cmd_ready = state_q == DBGACC_IDLE;
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_rdata = rsp_rdata_q;
   assign link.rsp_flags = rsp_flags_q;

   // Sequencer, memory request and the single-cycle response.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q     <= DBGACC_IDLE;
         mem_req     <= 1'b0;
         mem_we      <= 1'b0;
         mem_addr    <= `DBGACC_RST_ADDR;
         mem_be      <= 4'h0;
         mem_wdata   <= `DBGACC_RST_WORD;
         size_q      <= `DBGACC_SZ_8;
         shift_q     <= 5'h00;
         fetch_q     <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_rdata_q <= `DBGACC_RST_WORD;
         rsp_flags_q <= '0;
      end else begin
         rsp_valid_q <= 1'b0;
         case (state_q)
            DBGACC_IDLE: begin
               if (take) begin
                  rsp_flags_q <= '0;
                  rsp_rdata_q <= `DBGACC_RST_WORD;
                  if (mem_cmd && seq_ok) begin
                     state_q   <= DBGACC_MEM;
                     mem_req   <= 1'b1;
                     mem_we    <= is_wr | is_fill;
                     mem_addr  <= eff_addr;
                     size_q    <= sz;
                     shift_q   <= {~end_lane, 3'h0};
                     mem_be    <= {sz[1], sz[1], sz[1] | sz[0], 1'b1} << ~end_lane;
                     mem_wdata <= (link.cmd_wdata & size_mask(sz)) << {~end_lane, 3'h0};
                  end else if (mem_cmd) begin
                     // A stale streamed or repeated read gets the failure pattern.
                     rsp_valid_q <= 1'b1;
                     rsp_rdata_q <= (is_fill) ? `DBGACC_RST_WORD : `DBGACC_FAIL_WORD & size_mask(sz);
                  end else if ((is_sto | is_fet) && debug_halt_state
                               && link.cmd_op[3:0] <= `DBGACC_REG_LAST) begin
                     state_q <= DBGACC_REG;
                     fetch_q <= is_fet;
                  end else begin
                     rsp_valid_q <= 1'b1;
                     rsp_rdata_q <= is_sto ? `DBGACC_RST_WORD : `DBGACC_FAIL_WORD;
                     rsp_flags_q.bad_access <= (is_sto | is_fet) & debug_halt_state;
                     rsp_flags_q.bad_cmd    <= unimpl | ~debug_halt_state;
                  end
               end
            end
            DBGACC_MEM: begin
               if (mem_ack) begin
                  state_q     <= DBGACC_IDLE;
                  mem_req     <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  rsp_flags_q.bad_access <= mem_illegal;
                  rsp_flags_q.rd_invalid <= ~mem_we & mem_read_invalid_flag;
                  if (mem_we) begin
                     rsp_rdata_q <= `DBGACC_RST_WORD;
                  end else if (mem_illegal || mem_read_invalid_flag) begin
                     rsp_rdata_q <= `DBGACC_FAIL_WORD & size_mask(size_q);
                  end else begin
                     rsp_rdata_q <= (mem_rdata >> shift_q) & size_mask(size_q);
                  end
               end
            end
            DBGACC_REG: begin
               state_q     <= DBGACC_IDLE;
               rsp_valid_q <= 1'b1;
               rsp_rdata_q <= fetch_q ? (cpu_reg_rdata & reg_mask(cpu_reg_index))
                                      : `DBGACC_RST_WORD;
            end
            default: begin
               state_q <= DBGACC_IDLE;
               mem_req <= 1'b0;
            end
         endcase
      end
   end

   // CPU register port; the write strobe lasts one cycle and only when halted.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_reg_index <= 4'h0;
         cpu_reg_we    <= 1'b0;
         cpu_reg_wdata <= `DBGACC_RST_WORD;
      end else begin
         cpu_reg_we <= 1'b0;
         if (take && (is_sto || is_fet)) begin
            cpu_reg_index <= link.cmd_op[3:0];
            cpu_reg_wdata <= link.cmd_wdata & reg_mask(link.cmd_op[3:0]);
            cpu_reg_we    <= is_sto & debug_halt_state
                             & (link.cmd_op[3:0] <= `DBGACC_REG_LAST);
         end
      end
   end

   // Sequence bookkeeping: which streamed commands are valid and their addresses.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fill_ok_q   <= 1'b0;
         dump_ok_q   <= 1'b0;
         same_ok_q   <= 1'b0;
         last_addr_q <= `DBGACC_RST_ADDR;
         last_size_q <= `DBGACC_SZ_8;
         base_addr_q <= `DBGACC_RST_ADDR;
      end else if (take && unimpl) begin
         fill_ok_q <= 1'b0;
         dump_ok_q <= 1'b0;
         same_ok_q <= 1'b0;
      end else if (take && mem_cmd && seq_ok) begin
         if (!is_same) begin
            // Longwords continue from the zero-forced address, words from the original.
            last_addr_q <= (sz == `DBGACC_SZ_32) ? eff_addr : raw_addr;
            last_size_q <= sz;
         end
         if (is_rd) begin
            base_addr_q <= link.cmd_addr;
            same_ok_q   <= 1'b1;
            dump_ok_q   <= 1'b1;
            fill_ok_q   <= 1'b0;
         end else if (is_wr) begin
            fill_ok_q <= 1'b1;
            dump_ok_q <= 1'b0;
         end
      end else if (state_q == DBGACC_MEM && mem_ack && mem_illegal) begin
         // A read-invalid answer leaves the dump and same sequences usable.
         fill_ok_q <= 1'b0;
         same_ok_q <= 1'b0;
      end
   end

endmodule : dbgacc_dev

// file: pkg/dbgacc_consts.svh
// Constants of the debug access block: opcodes, sizes, fill values and host register map.
`ifndef DBGACC_CONSTS_SVH
`define DBGACC_CONSTS_SVH

// Command class, held in opcode bits [7:4].
`define DBGACC_CLS_WRITE_MEM 4'h1
`define DBGACC_CLS_FILL_MEM  4'h2
`define DBGACC_CLS_READ_MEM  4'h3
`define DBGACC_CLS_REG_STORE 4'h4
`define DBGACC_CLS_READ_SAME 4'h5
`define DBGACC_CLS_REG_FETCH 4'h6
`define DBGACC_CLS_DUMP_MEM  4'h7

// Memory access size, held in opcode bits [3:2].
`define DBGACC_SZ_8          2'h0
`define DBGACC_SZ_16         2'h1
`define DBGACC_SZ_32         2'h2

// Highest implemented CPU register index.
`define DBGACC_REG_LAST      4'hC

// Value returned in every byte of a failed read.
`define DBGACC_FAIL_WORD     32'hEEEEEEEE

// Host register byte offsets.
`define DBGACC_OFS_CMD       5'h00
`define DBGACC_OFS_ADDR      5'h04
`define DBGACC_OFS_WDATA     5'h08
`define DBGACC_OFS_RDATA     5'h0C
`define DBGACC_OFS_STATUS    5'h10
`define DBGACC_OFS_MASK      5'h14
`define DBGACC_OFS_BUSY      5'h18

// Status and mask bit positions.
`define DBGACC_ST_DONE       0
`define DBGACC_ST_BAD_ACC    1
`define DBGACC_ST_RD_INV     2
`define DBGACC_ST_BAD_CMD    3

// Reset values.
`define DBGACC_RST_ADDR      24'h000000
`define DBGACC_RST_WORD      32'h00000000
`define DBGACC_RST_FLAGS     4'h0

`endif

// file: pkg/dbgacc_pkg.sv
// Types shared by both ends of the debug access link.
package dbgacc_pkg;

   // Device end sequencer states.
   typedef enum logic [2:0] {
      DBGACC_IDLE = 3'b001,
      DBGACC_MEM  = 3'b010,
      DBGACC_REG  = 3'b100
   } dbgacc_state_t;

   // Response flags carried with every answer.
   typedef struct packed {
      logic bad_cmd;
      logic rd_invalid;
      logic bad_access;
   } dbgacc_flags_t;

endpackage : dbgacc_pkg

// file: pkg/dbgacc_link_if.sv
// Command level link between the debug host end and the device end.
`timescale 1ns/100ps
interface dbgacc_link_if;
   import dbgacc_pkg::*;

   logic          cmd_valid;
   logic          cmd_ready;
   logic [7:0]    cmd_op;
   logic [23:0]   cmd_addr;
   logic [31:0]   cmd_wdata;
   logic          rsp_valid;
   logic [31:0]   rsp_rdata;
   dbgacc_flags_t rsp_flags;

   modport host (output cmd_valid, cmd_op, cmd_addr, cmd_wdata,
                 input  cmd_ready, rsp_valid, rsp_rdata, rsp_flags);
   modport dev  (input  cmd_valid, cmd_op, cmd_addr, cmd_wdata,
                 output cmd_ready, rsp_valid, rsp_rdata, rsp_flags);
endinterface : dbgacc_link_if

// file: core/dbgacc_host.sv
// Host end: software issues debug commands through Avalon-MM registers.
`timescale 1ns/100ps
module dbgacc_host
   import dbgacc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rstn,
   // Avalon-MM slave.
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Interrupt.
   output logic             irq,
   // Link to the device.
   dbgacc_link_if.host      link
);
`include "dbgacc_consts.svh"

   logic        busy_q;
   logic        cmd_valid_q;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic [3:0]  status_q;
   logic [3:0]  mask_q;
   logic        rd_done_q;
   logic        wr_take;
   logic        launch;
   logic [3:0]  events;

   // A new command stalls the bus while one is in flight; reads take one wait cycle.
   assign avs_waitrequest = (avs_read & ~rd_done_q)
                            | (avs_write & (avs_address == `DBGACC_OFS_CMD) & busy_q);
   assign wr_take = avs_write & ~avs_waitrequest;
   assign launch  = wr_take & (avs_address == `DBGACC_OFS_CMD);
   assign events  = {link.rsp_flags.bad_cmd, link.rsp_flags.rd_invalid,
                     link.rsp_flags.bad_access, 1'b1} & {4{link.rsp_valid}};
   assign irq     = |(status_q & mask_q);

   assign link.cmd_valid = cmd_valid_q;
   assign link.cmd_op    = op_q;
   assign link.cmd_addr  = addr_q;
   assign link.cmd_wdata = wdata_q;

   // Command registers and the link request; the request drops when taken.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_q      <= 1'b0;
         cmd_valid_q <= 1'b0;
         op_q        <= 8'h00;
         addr_q      <= `DBGACC_RST_ADDR;
         wdata_q     <= `DBGACC_RST_WORD;
         rdata_q     <= `DBGACC_RST_WORD;
         mask_q      <= `DBGACC_RST_FLAGS;
      end else begin
         if (cmd_valid_q && link.cmd_ready) begin
            cmd_valid_q <= 1'b0;
         end
         if (link.rsp_valid) begin
            busy_q  <= 1'b0;
            rdata_q <= link.rsp_rdata;
         end
         if (launch) begin
            op_q        <= avs_writedata[7:0];
            cmd_valid_q <= 1'b1;
            busy_q      <= 1'b1;
         end
         if (wr_take && avs_address == `DBGACC_OFS_ADDR) begin
            addr_q <= avs_writedata[23:0];
         end
         if (wr_take && avs_address == `DBGACC_OFS_WDATA) begin
            wdata_q <= avs_writedata;
         end
         if (wr_take && avs_address == `DBGACC_OFS_MASK) begin
            mask_q <= avs_writedata[3:0];
         end
      end
   end

   // Sticky status, write one to clear; a new event wins over its clear.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= `DBGACC_RST_FLAGS;
      end else begin
         status_q <= (status_q & ~((wr_take && avs_address == `DBGACC_OFS_STATUS)
                                   ? avs_writedata[3:0] : 4'h0)) | events;
      end
   end

   // Registered read data; unmapped offsets read as zero.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_done_q    <= 1'b0;
         avs_readdata <= `DBGACC_RST_WORD;
      end else begin
         rd_done_q <= avs_read & ~rd_done_q;
         if (avs_read && !rd_done_q) begin
            case (avs_address)
               `DBGACC_OFS_CMD:    avs_readdata <= {24'h0, op_q};
               `DBGACC_OFS_ADDR:   avs_readdata <= {8'h0, addr_q};
               `DBGACC_OFS_WDATA:  avs_readdata <= wdata_q;
               `DBGACC_OFS_RDATA:  avs_readdata <= rdata_q;
               `DBGACC_OFS_STATUS: avs_readdata <= {28'h0, status_q};
               `DBGACC_OFS_MASK:   avs_readdata <= {28'h0, mask_q};
               `DBGACC_OFS_BUSY:   avs_readdata <= {31'h0, busy_q};
               default:            avs_readdata <= `DBGACC_RST_WORD;
            endcase
         end
      end
   end

endmodule : dbgacc_host

// file: tb/dbgacc_link_assertions.sv
// Concurrent checks on the link between the two ends.
`timescale 1ns/100ps
module dbgacc_link_assertions
   import dbgacc_pkg::*;
(
   // Clock and reset.
   input wire logic          clk,
   input wire logic          rstn,
   // Command side.
   input wire logic          cmd_valid,
   input wire logic          cmd_ready,
   input wire logic [7:0]    cmd_op,
   input wire logic [23:0]   cmd_addr,
   input wire logic [31:0]   cmd_wdata,
   // Answer side.
   input wire logic          rsp_valid,
   input wire logic [31:0]   rsp_rdata,
   input wire dbgacc_flags_t rsp_flags
);
   logic [7:0]  op_q;
   logic        busy_q;
   logic [31:0] keep;
   logic        rd_cls;

   // Command in flight, against which the answer is judged.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_q   <= 8'h00;
         busy_q <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         op_q   <= cmd_op;
         busy_q <= 1'b1;
      end else if (rsp_valid) begin
         busy_q <= 1'b0;
      end
   end

   // Meaningful bits of the fetched register; memory read classes.
   always_comb begin
      case (op_q[3:0])
         4'h0, 4'h1:                   keep = 32'h000000FF;
         4'h2, 4'h3, 4'h4, 4'h5, 4'hC: keep = 32'h0000FFFF;
         4'h6, 4'h7:                   keep = 32'hFFFFFFFF;
         default:                      keep = 32'h00FFFFFF;
      endcase
   end
   assign rd_cls = op_q[7:4] inside {4'h3, 4'h5, 4'h7};

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_take;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_reg_ans;
      ##[1:2] rsp_valid;
   endsequence

   AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_op)
      && $stable(cmd_addr) && $stable(cmd_wdata)) else $error("command changed");
   AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer too long");
   AST_RSP_CAUSE: assert property (rsp_valid |-> busy_q)
      else $error("stray answer");
   AST_READY_DROP: assert property (s_take ##0 (cmd_op[7:4] == 4'h3 && cmd_op[3:2] != 2'h3)
      |=> !cmd_ready) else $error("ready after read");
   AST_REG_ANS: assert property (s_take ##0 (cmd_op[7:4] == 4'h4 || cmd_op[7:4] == 4'h6)
      |-> s_reg_ans) else $error("register answer late");
   AST_BAD_IDX: assert property (rsp_valid && op_q[7:4] == 4'h6 && op_q[3:0] > 4'hC
      |-> rsp_rdata == 32'hEEEEEEEE && (rsp_flags.bad_access || rsp_flags.bad_cmd))
      else $error("bad index passed");
   AST_FETCH_WIDTH: assert property (rsp_valid && op_q[7:4] == 4'h6 && op_q[3:0] <= 4'hC
      && !rsp_flags.bad_cmd |-> (rsp_rdata & ~keep) == 32'h00000000)
      else $error("bits above width");
   AST_MEM8_WIDTH: assert property (rsp_valid && rd_cls && op_q[3:2] == 2'h0
      |-> rsp_rdata[31:8] == 24'h000000) else $error("byte read too wide");
   AST_BAD_CMD: assert property (s_take ##0 (cmd_op[7:4] == 4'h3 && cmd_op[3:2] == 2'h3)
      |=> rsp_valid && rsp_flags.bad_cmd) else $error("bad command taken");
endmodule : dbgacc_link_assertions

// file: tb/tb_top.sv
// Bench joining both ends, with register file and memory models.
`timescale 1ns/100ps
module tb_top;
   import dbgacc_pkg::*;
   typedef struct packed {logic [7:0] op; logic [23:0] a; logic [23:0] ea; logic [3:0] be;} dbgacc_row_t;
   localparam logic [31:0] DW = 32'h5A6B7C8D;
   localparam logic [31:0] MEMW = 32'hA1B2C3D4;
   logic        clk, rstn, av_r, av_w, av_wait, irq, halt, ill, read_invalid_flag, mem_ack;
   logic        rwe, mreq, mwe, la_we;
   logic [4:0]  av_a;
   logic [3:0]  ri, mbe, la_be;
   logic [23:0] maddr, la_a;
   logic [31:0] av_wd, av_rdata, rwd, mwd, la_wd, crd;
   logic [31:0] regs [13];
   int          acc_n, fails, check_count;
   dbgacc_row_t rows [20] = '{
      {8'h38, 24'h004003, 24'h004000, 4'hF}, {8'h78, 24'h0, 24'h004004, 4'hF},
      {8'h74, 24'h0, 24'h004008, 4'hC}, {8'h74, 24'h0, 24'h00400A, 4'h3},
      {8'h70, 24'h0, 24'h00400C, 4'h8}, {8'h74, 24'h0, 24'h00400D, 4'h6},
      {8'h74, 24'h0, 24'h00400E, 4'h3}, {8'h74, 24'h0, 24'h004011, 4'h6},
      {8'h30, 24'h004003, 24'h004003, 4'h1}, {8'h50, 24'h0, 24'h004003, 4'h1},
      {8'h54, 24'h0, 24'h004002, 4'h3}, {8'h58, 24'h0, 24'h004000, 4'hF},
      {8'h34, 24'h004001, 24'h004001, 4'h6}, {8'h50, 24'h0, 24'h004001, 4'h4},
      {8'h54, 24'h0, 24'h004001, 4'h6}, {8'h58, 24'h0, 24'h004000, 4'hF},
      {8'h14, 24'h004003, 24'h004002, 4'h3}, {8'h24, 24'h0, 24'h004005, 4'h6},
      {8'h28, 24'h0, 24'h004004, 4'hF}, {8'h20, 24'h0, 24'h004008, 4'h8}};

   dbgacc_link_if link();
   dbgacc_host i_dbgacc_host (.clk(clk), .rstn(rstn), .avs_address(av_a), .avs_read(av_r),
      .avs_write(av_w), .avs_writedata(av_wd), .avs_readdata(av_rdata),
      .avs_waitrequest(av_wait), .irq(irq), .link(link));
   dbgacc_dev i_dbgacc_dev (.clk(clk), .rstn(rstn), .link(link), .debug_halt_state(halt),
      .cpu_reg_index(ri), .cpu_reg_we(rwe), .cpu_reg_wdata(rwd), .cpu_reg_rdata(crd),
      .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr), .mem_be(mbe), .mem_wdata(mwd),
      .mem_ack(mem_ack), .mem_rdata(MEMW), .mem_illegal(ill), .mem_read_invalid_flag(read_invalid_flag));
   dbgacc_link_assertions i_dbgacc_link_assertions (.clk(clk), .rstn(rstn),
      .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op),
      .cmd_addr(link.cmd_addr), .cmd_wdata(link.cmd_wdata), .rsp_valid(link.rsp_valid),
      .rsp_rdata(link.rsp_rdata), .rsp_flags(link.rsp_flags));

   // Register file reads at once; unimplemented indexes read as zero.
   assign crd = (ri <= 4'hC) ? regs[ri] : 32'h00000000;
   always #10 clk = ~clk;

   // Memory acks one cycle after a request and keeps the last access.
   always @(posedge clk) begin
      mem_ack <= mreq && !mem_ack;
      if (mem_ack) begin
         la_we <= mwe;
         la_a  <= maddr;
         la_be <= mbe;
         la_wd <= mwd;
         acc_n <= acc_n + 1;
      end
      if (rwe) begin
         regs[ri] <= rwd;
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic lost;
      fails++;
      $display("BAD %0t no answer", $time);
      finish_test;
   endtask : lost

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t data %h expected %h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_a(input logic [28:0] exp);
      check_count++;
      if ({la_we, la_be, la_a} !== exp) begin
         fails++;
         $display("BAD %0t access %h expected %h", $time, {la_we, la_be, la_a}, exp);
      end
   endtask : chk_a

   // One bus cycle; waitrequest and read data are taken at the deciding edge.
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      logic w = 1'b1;
      @(posedge clk);
      av_a  <= a;
      av_r  <= !wr;
      av_w  <= wr;
      av_wd <= d;
      for (int n = 0; n < 40 && w !== 1'b0; n++) begin
         @(posedge clk);
         w = av_wait;
         q = av_rdata;
      end
      if (w !== 1'b0) lost;
      av_r <= 1'b0;
      av_w <= 1'b0;
   endtask : av

   // One command: launch, wait until idle, fetch data and status, clear status.
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [3:0] st);
      logic [31:0] q;
      av(1'b1, 5'h04, {8'h00, a}, q);
      av(1'b1, 5'h08, d, q);
      av(1'b1, 5'h00, {24'h000000, op}, q);
      q = 32'h1;
      for (int n = 0; n < 40 && q[0] !== 1'b0; n++) av(1'b0, 5'h18, 32'h0, q);
      if (q[0] !== 1'b0) lost;
      av(1'b0, 5'h0C, 32'h0, rd);
      av(1'b0, 5'h10, 32'h0, q);
      st = q[3:0];
      av(1'b1, 5'h10, 32'h0000000F, q);
   endtask : cmd

   task automatic t_regs;
      logic [31:0] rd, m;
      logic [3:0]  st;
      for (int i = 0; i < 13; i++) begin
         m = i < 2 ? 32'hFF : (i < 6 || i == 12) ? 32'hFFFF : i < 8 ? 32'hFFFFFFFF : 32'hFFFFFF;
         cmd(8'h40 + 8'(i), 24'h0, DW, rd, st);
         chk_w(regs[i] & m, DW & m);
         regs[i] = 32'hFFFFFFFF;
         cmd(8'h60 + 8'(i), 24'h0, 32'h0, rd, st);
         chk_w(rd, m);
      end
      for (int i = 13; i < 16; i++) begin
         cmd(8'h40 + 8'(i), 24'h0, DW, rd, st);
         chk_w({28'h0, st}, 32'h3);
         cmd(8'h60 + 8'(i), 24'h0, 32'h0, rd, st);
         chk_w(rd ^ {28'h0, st}, 32'hEEEEEEED);
      end
      halt <= 1'b0;
      cmd(8'h47, 24'h0, DW, rd, st);
      chk_w(regs[7] ^ {28'h0, st}, 32'hFFFFFFF6);
      halt <= 1'b1;
   endtask : t_regs

   // Realignment, streamed and repeated-base accesses from one table.
   task automatic t_stream;
      logic [31:0] rd, m;
      logic [3:0]  st;
      int          s;
      for (int i = 0; i < 20; i++) begin
         cmd(rows[i].op, rows[i].a, DW, rd, st);
         s = rows[i].be[0] ? 0 : rows[i].be[1] ? 8 : rows[i].be[2] ? 16 : 24;
         m = rows[i].op[3:2] == 2'h0 ? 32'hFF : rows[i].op[3:2] == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
         chk_a({rows[i].op[7:4] < 4'h3, rows[i].be, rows[i].ea});
         if (rows[i].op[7:4] < 4'h3) chk_w((la_wd >> s) & m, DW & m);
         else chk_w(rd, (MEMW >> s) & m);
         chk_w({28'h0, st}, 32'h1);
      end
   endtask : t_stream

   task automatic t_ill;
      logic [31:0] rd;
      logic [3:0]  st;
      int          n;
      cmd(8'h30, 24'h004000, 32'h0, rd, st);
      ill <= 1'b1;
      cmd(8'h70, 24'h0, 32'h0, rd, st);
      chk_w(rd ^ {28'h0, st}, 32'hED);
      ill <= 1'b0;
      cmd(8'h70, 24'h0, 32'h0, rd, st);
      chk_a({1'b0, 4'h2, 24'h004002});
      n = acc_n;
      cmd(8'h50, 24'h0, 32'h0, rd, st);
      chk_w(rd ^ 32'(acc_n - n), 32'hEE);
      read_invalid_flag <= 1'b1;
      cmd(8'h30, 24'h004001, 32'h0, rd, st);
      chk_w(rd ^ {28'h0, st}, 32'hEB);
      read_invalid_flag <= 1'b0;
      cmd(8'h50, 24'h0, 32'h0, rd, st);
      chk_a({1'b0, 4'h4, 24'h004001});
      cmd(8'h70, 24'h0, 32'h0, rd, st);
      chk_a({1'b0, 4'h2, 24'h004002});
      cmd(8'h3C, 24'h0, 32'h0, rd, st);
      chk_w({28'h0, st}, 32'h9);
      n = acc_n;
      cmd(8'h70, 24'h0, 32'h0, rd, st);
      chk_w(rd ^ 32'(acc_n - n), 32'hEE);
   endtask : t_ill

   // Interrupt from a refused command: mask, unmask, clear; unmapped read.
   task automatic t_irq;
      logic [31:0] q;
      av(1'b1, 5'h14, 32'hF, q);
      av(1'b1, 5'h00, 32'h3C, q);
      repeat (2) av(1'b0, 5'h18, 32'h0, q);
      @(negedge clk);
      chk_w(32'(irq), 32'h1);
      av(1'b1, 5'h14, 32'h0, q);
      @(negedge clk);
      chk_w(32'(irq), 32'h0);
      av(1'b1, 5'h14, 32'hF, q);
      av(1'b1, 5'h10, 32'hF, q);
      @(negedge clk);
      chk_w(32'(irq), 32'h0);
      av(1'b0, 5'h1C, 32'h0, q);
      chk_w(q, 32'h0);
   endtask : t_irq

   initial begin
      clk     = 1'b0;
      rstn    = 1'b0;
      av_r    = 1'b0;
      av_w    = 1'b0;
      halt    = 1'b1;
      ill     = 1'b0;
      read_invalid_flag   = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_stream;
      t_ill;
      t_irq;
      finish_test;
   end
endmodule : tb_top
